// >>> hw/mad_map.vh
// field layout and constants of the microcoded arithmetic/address datapath
`ifndef MAD_MAP_VH
`define MAD_MAP_VH
`define MAD_IW 160
`define MAD_F_FRZ 0
`define MAD_F_HALF 1
`define MAD_F_MLS 4
`define MAD_F_MRS 12
`define MAD_F_AOP 16
`define MAD_F_ASA 28
`define MAD_F_ASB 36
`define MAD_F_RLD 44
`define MAD_F_XRA 56
`define MAD_F_XWA 60
`define MAD_F_YRA 64
`define MAD_F_YWA 68
`define MAD_F_SWE 72
`define MAD_F_XSRC 76
`define MAD_F_YSRC 79
`define MAD_F_PAIR 82
`define MAD_F_ZLD 84
`define MAD_F_CHA 86
`define MAD_F_CHB 88
`define MAD_F_CHAS 90
`define MAD_F_CHBS 92
`define MAD_F_AGU 96
`define MAD_AGU_W 12
`define MAD_F_WADR 132
`define MAD_F_WWE 136
`define MAD_F_WSRC 137
`define MAD_F_LIT 144
`define MAD_G_OP 0
`define MAD_G_SA 3
`define MAD_G_SB 5
`define MAD_G_RLD 7
`define MAD_G_ALD 8
`define MAD_G_SLD 9
`define MAD_G_SH 10
`define MAD_OP_ADD 3'h0
`define MAD_OP_SUB 3'h1
`define MAD_OP_AND 3'h2
`define MAD_OP_OR 3'h3
`define MAD_OP_XOR 3'h4
`define MAD_OP_PA 3'h5
`define MAD_OP_PB 3'h6
`define MAD_OP_RSUB 3'h7
`define MAD_CH_RD 2'h1
`define MAD_CH_WR 2'h2
`define MAD_SH_L 2'h1
`define MAD_SH_R 2'h2
`define MAD_STAT_BIT 11
`define MAD_SLICES 3'h5
`define MAD_IDX_ADDR 3'h0
`define MAD_IDX_S12 3'h1
`define MAD_IDX_S34 3'h2
`define MAD_IDX_UPC 3'h3
`define MAD_IDX_P12 3'h4
`define MAD_IDX_STALL 3'h5
`endif

// >>> hw/mad_mult.v
// two-stage pipelined signed multiplier with selectable product half
`timescale 1ns/1ps
`include "mad_map.vh"
module mad_mult #(
  parameter W = 16
) (
  // clock and control
  input wire ref_clk,
  input wire rstn,
  input wire adv,
  input wire half_hi,
  // operands and product
  input wire [W-1:0] opa,
  input wire [W-1:0] opb,
  output reg [W-1:0] prod_ff
);
  reg [2*W-1:0] part_ff;
  reg hi_ff;
  wire signed [2*W-1:0] full = $signed(opa) * $signed(opb);
  always @(posedge ref_clk) begin
    if (!rstn) begin
      part_ff <= {2*W{1'b0}};
      hi_ff <= 1'b0;
      prod_ff <= {W{1'b0}};
    end else if (adv) begin
      part_ff <= full;
      // the half choice travels with its operands
      hi_ff <= half_hi;
      prod_ff <= hi_ff ? part_ff[2*W-1:W] : part_ff[W-1:0];
    end
  end
endmodule // mad_mult

// >>> hw/mad_addr_unit.v
// one 12-bit address formation unit: alu, result, address and step
`timescale 1ns/1ps
`include "mad_map.vh"
module mad_addr_unit (
  // clock and control
  input wire ref_clk,
  input wire rstn,
  input wire adv,
  input wire [11:0] ctrl,
  // operand sources
  input wire [11:0] scr,
  input wire [11:0] literal_field,
  // registers
  output reg [11:0] addr_ff,
  output reg [11:0] step_ff,
  output reg [11:0] result_ff
);
  wire [1:0] sh = ctrl[`MAD_G_SH +: 2];
  wire [1:0] sa = ctrl[`MAD_G_SA +: 2];
  wire [1:0] sb = ctrl[`MAD_G_SB +: 2];
  wire [2:0] op = ctrl[`MAD_G_OP +: 3];
  // shift happens before the alu sees the step
  wire [11:0] step_sh = (sh == `MAD_SH_L) ? {step_ff[10:0], 1'b0} :
    (sh == `MAD_SH_R) ? {step_ff[11], step_ff[11:1]} : step_ff;
  wire [11:0] a = (sa == 2'h0) ? addr_ff : (sa == 2'h1) ? step_sh :
    (sa == 2'h2) ? scr : literal_field;
  wire [11:0] b = (sb == 2'h0) ? addr_ff : (sb == 2'h1) ? step_sh :
    (sb == 2'h2) ? scr : literal_field;
  reg [11:0] y;
  always @* begin
    case (op)
      `MAD_OP_ADD: y = a + b;
      `MAD_OP_SUB: y = a - b;
      `MAD_OP_AND: y = a & b;
      `MAD_OP_OR: y = a | b;
      `MAD_OP_XOR: y = a ^ b;
      `MAD_OP_PA: y = a;
      `MAD_OP_PB: y = b;
      default: y = b - a;
    endcase
  end
  always @(posedge ref_clk) begin
    if (!rstn) begin
      addr_ff <= 12'h000;
      step_ff <= 12'h000;
      result_ff <= 12'h000;
    end else if (adv) begin
      if (ctrl[`MAD_G_RLD]) result_ff <= y;
      if (ctrl[`MAD_G_ALD]) addr_ff <= result_ff;
      step_ff <= ctrl[`MAD_G_SLD] ? result_ff : step_sh;
    end
  end
endmodule // mad_addr_unit

// >>> hw/mad_datapath.v
// microcoded arithmetic and address datapath, top level
// What this block does
// - 256 words of 160-bit microcode feed an instruction register.
// - microcode store loads only in blocks from the external loader.
// - two bidirectional 32-bit channels, each moving two 16-bit words.
// - four signed 16x16 multipliers write truncated products to own reg.
// - multipliers one/two pick upper or lower half; three/four upper.
// - multipliers take operands each cycle, product two cycles later.
// - a microcode bit freezes all multiplier pipelines.
// - four 16-bit ALUs, one selectable function each per cycle.
// - ALU two takes ALU one output, ALU four takes ALU three.
// - two 16x32 local stores, one read and one write per cycle.
// - store halves share address but write independently.
// - left buffer half maps to store upper, right to lower.
// - stores feed channels, arithmetic, scratch; fed by many sources.
// - coefficient regs load 12-bit quarters of 48-bit ROM word.
// - coefficient regs may load the selected store half inputs.
// - sum regs load own ALU, neighbour ALU, product or literal.
// - sum regs leave in pairs one-two, three-four, one-three, two-four.
// - three address units for A, B and ROM, same instruction.
// - address ALUs work on 12 bits from address, step, scratch, literal.
// - each address ALU writes its own 12-bit result register.
// - address registers present addresses, loaded from result register.
// - step registers shift both ways and load from result register.
// - step shift happens before the cycle's ALU results are stored.
// - scratch gets 12 bits sign-filled to 16; reads low 11 plus sign.
`timescale 1ns/1ps
`include "mad_map.vh"
module mad_datapath #(
  parameter UC_DEPTH = 256,
  parameter UC_AW = 8
) (
  // clock, reset, enable
  input wire ref_clk,
  input wire rstn,
  input wire ce,
  // register port
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_ff,
  // buffer channel a
  output wire cha_req,
  output wire cha_we,
  output wire [11:0] cha_addr,
  input wire cha_gnt,
  input wire [31:0] cha_d_in,
  output wire [31:0] cha_d_out,
  output wire cha_d_oe,
  // buffer channel b
  output wire chb_req,
  output wire chb_we,
  output wire [11:0] chb_addr,
  input wire chb_gnt,
  input wire [31:0] chb_d_in,
  output wire [31:0] chb_d_out,
  output wire chb_d_oe,
  // constant rom
  output wire [11:0] rom_addr,
  input wire [47:0] rom_data,
  // status
  output wire stall
);
  reg [`MAD_IW-1:0] ucode [0:UC_DEPTH-1];
  reg [`MAD_IW-1:0] instr_holding_reg_ff;
  reg [UC_AW-1:0] microcode_addr_reg_ff;
  reg [31:0] sta [0:15];
  reg [31:0] stb [0:15];
  reg [15:0] scr [0:15];
  reg [63:0] sum_ff;
  reg [63:0] coeff_ff;
  wire [63:0] prod;
  wire [63:0] alu_y;
  wire [63:0] nxt_sum;
  wire [63:0] nxt_coeff;
  wire [35:0] g_addr;
  wire [35:0] g_step;
  wire [35:0] g_res;
  wire [`MAD_IW-1:0] ir = instr_holding_reg_ff;
  wire [15:0] literal_field = ir[`MAD_F_LIT +: 16];
  wire [11:0] lit12 = {literal_field[15], literal_field[10:0]};

  // a denied channel freezes fetch and execution until the grant comes; port writes still land
  assign stall = (cha_req & ~cha_gnt) | (chb_req & ~chb_gnt);
  wire run = ce & ~stall;
  wire stat = reg_addr[`MAD_STAT_BIT];
  wire [2:0] idx = reg_addr[2:0];

  // fetch: the next word is read one instruction ahead
  always @(posedge ref_clk) begin
    if (!rstn) begin
      instr_holding_reg_ff <= {`MAD_IW{1'b0}};
      microcode_addr_reg_ff <= {UC_AW{1'b0}};
    end else if (ce) begin
      if (reg_wr & stat & (idx == `MAD_IDX_UPC)) begin
        microcode_addr_reg_ff <= reg_wdata[UC_AW-1:0];
      end else if (run) begin
        instr_holding_reg_ff <= ucode[microcode_addr_reg_ff];
        microcode_addr_reg_ff <= microcode_addr_reg_ff + 1'b1;
      end
    end
  end

  // microcode is loaded in 32-bit slices by the external block loader
  always @(posedge ref_clk) begin
    if (ce & reg_wr & ~stat & (idx < `MAD_SLICES)) begin
      ucode[reg_addr[UC_AW+2:3]][{idx, 5'h00} +: 32] <= reg_wdata;
    end
  end

  // store reads and the half lanes used by the arithmetic
  wire [31:0] sta_rd = sta[ir[`MAD_F_XRA +: 4]];
  wire [31:0] stb_rd = stb[ir[`MAD_F_YRA +: 4]];
  wire [63:0] halves = {stb_rd[15:0], stb_rd[31:16],
    sta_rd[15:0], sta_rd[31:16]};
  wire [15:0] scr_rd = scr[ir[`MAD_F_WADR +: 4]];
  wire [11:0] scr12 = {scr_rd[15], scr_rd[10:0]};

  // result pairs for channel output and store input
  wire [1:0] pair_sel = ir[`MAD_F_PAIR +: 2];
  wire [31:0] pair = (pair_sel == 2'h0) ? {sum_ff[15:0], sum_ff[31:16]} :
    (pair_sel == 2'h1) ? {sum_ff[47:32], sum_ff[63:48]} :
    (pair_sel == 2'h2) ? {sum_ff[15:0], sum_ff[47:32]} :
    {sum_ff[31:16], sum_ff[63:48]};

  // store input selection
  function [31:0] st_in;
    input [2:0] sel;
    input [31:0] da;
    input [31:0] db;
    input [31:0] pr;
    input [15:0] lv;
    input [15:0] sv;
    input [11:0] aa;
    input [11:0] ab;
    begin
      case (sel)
        3'h0: st_in = da;
        3'h1: st_in = db;
        3'h2: st_in = pr;
        3'h3: st_in = {lv, lv};
        3'h4: st_in = {sv, sv};
        3'h5: st_in = {4'h0, aa, 4'h0, ab};
        default: st_in = 32'h00000000;
      endcase
    end
  endfunction

  wire [31:0] xin = st_in(ir[`MAD_F_XSRC +: 3], cha_d_in, chb_d_in, pair,
    literal_field, scr_rd, cha_addr, chb_addr);
  wire [31:0] yin = st_in(ir[`MAD_F_YSRC +: 3], cha_d_in, chb_d_in, pair,
    literal_field, scr_rd, cha_addr, chb_addr);
  wire [63:0] in_halves = {yin[15:0], yin[31:16], xin[15:0], xin[31:16]};

  // local store writes, each half on its own enable
  wire [3:0] swe = ir[`MAD_F_SWE +: 4];
  wire [3:0] xwa = ir[`MAD_F_XWA +: 4];
  wire [3:0] ywa = ir[`MAD_F_YWA +: 4];
  always @(posedge ref_clk) begin
    if (run) begin
      if (swe[0]) sta[xwa][31:16] <= xin[31:16];
      if (swe[1]) sta[xwa][15:0] <= xin[15:0];
      if (swe[2]) stb[ywa][31:16] <= yin[31:16];
      if (swe[3]) stb[ywa][15:0] <= yin[15:0];
    end
  end

  // 16-bit alu shared by the four arithmetic lanes
  function [15:0] alu16;
    input [2:0] op;
    input [15:0] a;
    input [15:0] b;
    begin
      case (op)
        `MAD_OP_ADD: alu16 = a + b;
        `MAD_OP_SUB: alu16 = a - b;
        `MAD_OP_AND: alu16 = a & b;
        `MAD_OP_OR: alu16 = a | b;
        `MAD_OP_XOR: alu16 = a ^ b;
        `MAD_OP_PA: alu16 = a;
        `MAD_OP_PB: alu16 = b;
        default: alu16 = b - a;
      endcase
    end
  endfunction

  wire freeze = ir[`MAD_F_FRZ];
  wire [1:0] zld = ir[`MAD_F_ZLD +: 2];

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      wire [1:0] mls = ir[`MAD_F_MLS + 2*i +: 2];
      wire [1:0] asa = ir[`MAD_F_ASA + 2*i +: 2];
      wire [1:0] asb = ir[`MAD_F_ASB + 2*i +: 2];
      wire [2:0] rld = ir[`MAD_F_RLD + 3*i +: 3];
      wire [15:0] own_h = halves[16*i +: 16];
      wire [15:0] oth_h = halves[16*(i^2) +: 16];
      wire [15:0] own_s = sum_ff[16*i +: 16];
      wire [15:0] own_p = prod[16*i +: 16];
      wire [15:0] ml = (mls == 2'h0) ? own_h : (mls == 2'h1) ? own_s :
        (mls == 2'h2) ? own_p : oth_h;
      // coefficients only ever reach the right-hand multiplier input
      wire [15:0] mr = ir[`MAD_F_MRS + i] ? own_s :
        coeff_ff[16*i +: 16];
      wire hi;
      wire [15:0] chain;
      if (i >= 2) begin : g_hi
        assign hi = 1'b1;
      end else begin : g_sel
        assign hi = ir[`MAD_F_HALF + i];
      end
      if (i % 2 == 1) begin : g_chain
        assign chain = alu_y[16*(i-1) +: 16];
      end else begin : g_nochain
        assign chain = sum_ff[16*(i+1) +: 16];
      end
      wire [15:0] aa = (asa == 2'h0) ? own_p : (asa == 2'h1) ? own_h :
        (asa == 2'h2) ? own_s : chain;
      wire [15:0] ab = (asb == 2'h0) ? own_p : (asb == 2'h1) ? own_h :
        (asb == 2'h2) ? own_s : literal_field;
      assign alu_y[16*i +: 16] =
        alu16(ir[`MAD_F_AOP + 3*i +: 3], aa, ab);
      assign nxt_sum[16*i +: 16] = (rld == 3'h1) ? alu_y[16*i +: 16] :
        (rld == 3'h2) ? alu_y[16*(i^1) +: 16] :
        (rld == 3'h3) ? own_p :
        (rld == 3'h4) ? literal_field : own_s;
      // rom quarters are fractions, so they sit left-justified
      assign nxt_coeff[16*i +: 16] =
        (zld == 2'h1) ? {rom_data[47-12*i -: 12], 4'h0} :
        (zld == 2'h2) ? in_halves[16*i +: 16] :
        coeff_ff[16*i +: 16];
      mad_mult #(
        .W(16)
      ) u_mult (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .adv(run & ~freeze),
        .half_hi(hi),
        .opa(ml),
        .opb(mr),
        .prod_ff(prod[16*i +: 16])
      );
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (!rstn) begin
      sum_ff <= 64'h0000000000000000;
      coeff_ff <= 64'h0000000000000000;
    end else if (run) begin
      sum_ff <= nxt_sum;
      coeff_ff <= nxt_coeff;
    end
  end

  // address section, stepping in the same cycle as the arithmetic
  genvar u;
  generate
    for (u = 0; u < 3; u = u + 1) begin : g_agu
      mad_addr_unit u_agu (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .adv(run),
        .ctrl(ir[`MAD_F_AGU + `MAD_AGU_W*u +: 12]),
        .scr(scr12),
        .literal_field(lit12),
        .addr_ff(g_addr[12*u +: 12]),
        .step_ff(g_step[12*u +: 12]),
        .result_ff(g_res[12*u +: 12])
      );
    end
  endgenerate

  assign cha_addr = g_addr[11:0];
  assign chb_addr = g_addr[23:12];
  assign rom_addr = g_addr[35:24];

  // scratch store: address results are sign-filled on the way in
  wire [1:0] wsrc = ir[`MAD_F_WSRC +: 2];
  wire [11:0] wres = (wsrc == 2'h0) ? g_res[11:0] :
    (wsrc == 2'h1) ? g_res[23:12] : g_res[35:24];
  wire [15:0] scr_wd = (wsrc == 2'h3) ? sta_rd[31:16] :
    {{5{wres[11]}}, wres[10:0]};
  always @(posedge ref_clk) begin
    if (run & ir[`MAD_F_WWE]) begin
      scr[ir[`MAD_F_WADR +: 4]] <= scr_wd;
    end
  end

  // buffer channels; data lanes are left word half first
  wire [1:0] cha_op = ir[`MAD_F_CHA +: 2];
  wire [1:0] chb_op = ir[`MAD_F_CHB +: 2];
  wire [1:0] cha_src = ir[`MAD_F_CHAS +: 2];
  wire [1:0] chb_src = ir[`MAD_F_CHBS +: 2];
  // at most one transfer per channel per instruction, two in all
  assign cha_req = ce & ((cha_op == `MAD_CH_RD) | cha_we);
  assign chb_req = ce & ((chb_op == `MAD_CH_RD) | chb_we);
  assign cha_we = ce & (cha_op == `MAD_CH_WR);
  assign chb_we = ce & (chb_op == `MAD_CH_WR);
  assign cha_d_out = (cha_src == 2'h0) ? sta_rd :
    (cha_src == 2'h1) ? stb_rd : pair;
  assign chb_d_out = (chb_src == 2'h0) ? sta_rd :
    (chb_src == 2'h1) ? stb_rd : pair;
  assign cha_d_oe = cha_we;
  assign chb_d_oe = chb_we;

  // register port readback
  always @(posedge ref_clk) begin
    if (!rstn) begin
      reg_rdata_ff <= 32'h00000000;
    end else if (ce) begin
      if (!reg_rd) begin
        reg_rdata_ff <= 32'h00000000;
      end else if (!stat) begin
        reg_rdata_ff <= (idx < `MAD_SLICES) ?
          ucode[reg_addr[UC_AW+2:3]][{idx, 5'h00} +: 32] : 32'h00000000;
      end else begin
        case (idx)
          `MAD_IDX_ADDR: reg_rdata_ff <= {4'h0, chb_addr, 4'h0, cha_addr};
          `MAD_IDX_S12: reg_rdata_ff <= {sum_ff[31:16], sum_ff[15:0]};
          `MAD_IDX_S34: reg_rdata_ff <= {sum_ff[63:48], sum_ff[47:32]};
          `MAD_IDX_UPC: reg_rdata_ff <=
            {{(32-UC_AW){1'b0}}, microcode_addr_reg_ff};
          `MAD_IDX_P12: reg_rdata_ff <= prod[31:0];
          `MAD_IDX_STALL: reg_rdata_ff <= {31'h00000000, stall};
          default: reg_rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // mad_datapath

// >>> bench/mad_bufmem.sv
// buffer memory model for one 32-bit channel, grant after a set delay
`timescale 1ns/1ps
module mad_bufmem (
  // clock
  input wire ref_clk,
  // grant delay chosen by the bench
  input wire [3:0] dly,
  // channel from the datapath
  input wire req,
  input wire we,
  input wire [11:0] addr,
  input wire [31:0] d_out,
  input wire d_oe,
  // channel back to the datapath
  output wire gnt,
  output reg [31:0] d_in
);
  reg [31:0] mem [0:4095];
  reg [3:0] wait_ff;
  reg [31:0] junk_ff;
  wire take;
  integer n;
  // zero delay grants even an unknown request, so a stray x cannot stall
  assign gnt = (dly == 4'h0) || (wait_ff >= dly);
  assign take = (req === 1'b1) && gnt;
  initial begin
    wait_ff = 4'h0;
    junk_ff = 32'h5a5a0ff0;
    for (n = 0; n < 4096; n = n + 1) begin
      mem[n] = {n[15:0], ~n[15:0]};
    end
  end
  // a read that is not granted sees a changing line, never stale data
  always @* begin
    d_in = (take && we === 1'b0) ? mem[addr] : junk_ff;
  end
  always @(posedge ref_clk) begin
    junk_ff <= {junk_ff[30:0], ~junk_ff[31]};
    wait_ff <= (req === 1'b1 && !gnt) ? wait_ff + 4'h1 : 4'h0;
    if (take && we === 1'b1 && d_oe === 1'b1) begin
      mem[addr] <= d_out;
    end
  end
endmodule // mad_bufmem

// >>> bench/mad_checker.sv
// port assertions for the datapath top, attached by bind
`timescale 1ns/1ps
module mad_checker (
  // clock and reset
  input wire ref_clk,
  input wire rstn,
  input wire ce,
  // register port
  input wire [11:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_ff,
  // channels
  input wire cha_req,
  input wire cha_we,
  input wire cha_gnt,
  input wire [31:0] cha_d_out,
  input wire cha_d_oe,
  input wire [11:0] cha_addr,
  input wire chb_req,
  input wire chb_we,
  input wire chb_gnt,
  input wire chb_d_oe,
  input wire [11:0] chb_addr,
  // rom and status
  input wire [11:0] rom_addr,
  input wire stall
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_stall_def: assert property (stall ==
    ((cha_req && !cha_gnt) || (chb_req && !chb_gnt)))
    else $error("stall differs from ungranted request");
  chk_stall_ce: assert property (stall |-> ce)
    else $error("stall raised while disabled");
  chk_stall_addr: assert property (stall |=> $stable(cha_addr) &&
    $stable(chb_addr) && $stable(rom_addr))
    else $error("address moved during stall");
  chk_reqa_hold: assert property (cha_req && !cha_gnt |=> !ce ||
    (cha_req && $stable(cha_we) && $stable(cha_addr)))
    else $error("channel a request dropped before grant");
  chk_reqb_hold: assert property (chb_req && !chb_gnt |=> !ce ||
    (chb_req && $stable(chb_we) && $stable(chb_addr)))
    else $error("channel b request dropped before grant");
  chk_wdata_hold: assert property (cha_req && cha_we && !cha_gnt
    |=> !ce || $stable(cha_d_out))
    else $error("channel a write data moved before grant");
  chk_drive_dir: assert property ((cha_req |-> cha_d_oe == cha_we) and
    (chb_req |-> chb_d_oe == chb_we))
    else $error("drive enable differs from write");
  chk_rdata_idle: assert property (ce && !reg_rd |=>
    reg_rdata_ff == 32'h0)
    else $error("read data not zero without read");
  chk_slice_void: assert property (ce && reg_rd && !reg_addr[11] &&
    reg_addr[2:0] > 3'h4 |=> reg_rdata_ff == 32'h0)
    else $error("slice beyond word read nonzero");
  chk_stat_stall: assert property (ce && reg_rd && reg_addr == 12'h805
    |=> reg_rdata_ff == {31'h0, $past(stall)})
    else $error("stall status wrong");
  chk_stat_addr: assert property (ce && reg_rd && reg_addr == 12'h800
    |=> reg_rdata_ff == {4'h0, $past(chb_addr), 4'h0, $past(cha_addr)})
    else $error("address status wrong");
endmodule // mad_checker
bind mad_datapath mad_checker u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .cha_req(cha_req), .cha_we(cha_we),
  .cha_gnt(cha_gnt), .cha_d_out(cha_d_out), .cha_d_oe(cha_d_oe),
  .cha_addr(cha_addr), .chb_req(chb_req), .chb_we(chb_we),
  .chb_gnt(chb_gnt), .chb_d_oe(chb_d_oe), .chb_addr(chb_addr),
  .rom_addr(rom_addr), .stall(stall));

// >>> bench/testbench.sv
// self-checking bench: program load, register port and channel stall
`timescale 1ns/1ps
`include "mad_map.vh"
module testbench;
  reg ref_clk, rstn, ce, reg_wr, reg_rd, rd_q;
  reg [11:0] reg_addr;
  reg [31:0] reg_wdata;
  reg [47:0] rom_data;
  reg [3:0] dly_a;
  wire [31:0] reg_rdata_ff, cha_d_in, cha_d_out, chb_d_in, chb_d_out;
  wire cha_req, cha_we, cha_gnt, cha_d_oe, stall;
  wire chb_req, chb_we, chb_gnt, chb_d_oe;
  wire [11:0] cha_addr, chb_addr, rom_addr;
  logic [31:0] exp_q[$];
  logic [159:0] word, rd_instr;
  int fail_count, check_count, seed_ret, i, k;
  mad_datapath u_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .cha_req(cha_req),
    .cha_we(cha_we), .cha_addr(cha_addr), .cha_gnt(cha_gnt),
    .cha_d_in(cha_d_in), .cha_d_out(cha_d_out), .cha_d_oe(cha_d_oe),
    .chb_req(chb_req), .chb_we(chb_we), .chb_addr(chb_addr),
    .chb_gnt(chb_gnt), .chb_d_in(chb_d_in), .chb_d_out(chb_d_out),
    .chb_d_oe(chb_d_oe), .rom_addr(rom_addr), .rom_data(rom_data),
    .stall(stall));
  mad_bufmem u_mem_a (.ref_clk(ref_clk), .dly(dly_a), .req(cha_req),
    .we(cha_we), .addr(cha_addr), .d_out(cha_d_out), .d_oe(cha_d_oe),
    .gnt(cha_gnt), .d_in(cha_d_in));
  mad_bufmem u_mem_b (.ref_clk(ref_clk), .dly(4'h0), .req(chb_req),
    .we(chb_we), .addr(chb_addr), .d_out(chb_d_out), .d_oe(chb_d_oe),
    .gnt(chb_gnt), .d_in(chb_d_in));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task summarize;
    begin
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task check_word(input string name, input [31:0] e, input [31:0] s);
    begin
      check_count++;
      if (s !== e) begin
        fail_count++;
        $display("Error %s: expected %h seen %h", name, e, s);
      end
    end
  endtask
  task reg_write(input [11:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      rom_data <= {16'($urandom), 32'($urandom)};
    end
  endtask
  task reg_read(input [11:0] a, input [31:0] e);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
    end
  endtask
  task idle(input int n);
    begin
      repeat (n) begin
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
      end
    end
  endtask
  task put_word(input [7:0] n, input [159:0] w);
    int s;
    begin
      for (s = 0; s < 5; s++) reg_write({1'b0, n, 3'(s)}, w[32*s +: 32]);
    end
  endtask
  task get_word(input [7:0] n, input [159:0] w);
    int s;
    begin
      for (s = 0; s < 5; s++) reg_read({1'b0, n, 3'(s)}, w[32*s +: 32]);
    end
  endtask
  task do_reset;
    begin
      idle(1);
      rstn <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
    end
  endtask
  // bounded wait at the falling edge, for request high or stall gone
  task wait_for(input bit want_req);
    int n;
    begin
      n = 0;
      @(negedge ref_clk);
      while ((want_req ? cha_req : !stall) !== 1'b1) begin
        n++;
        if (n > 30) begin
          fail_count++;
          $display("Error channel wait: expected 1 seen 0");
          summarize();
        end
        @(negedge ref_clk);
      end
    end
  endtask
  // results arrive one cycle after the read strobe and only then
  always @(posedge ref_clk) rd_q <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        check_word("reg_rdata_ff", 32'hx, reg_rdata_ff);
      end else begin
        check_word("reg_rdata_ff", exp_q.pop_front(), reg_rdata_ff);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    $display("Error watchdog: expected end seen hang");
    summarize();
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd_q = 1'b0;
    rom_data = 48'h0;
    dly_a = 4'h0;
    fail_count = 0;
    check_count = 0;
    seed_ret = $urandom(32'h0b1916de);
    rd_instr = 160'h0;
    rd_instr[`MAD_F_CHA +: 2] = `MAD_CH_RD;
    rd_instr[`MAD_F_SWE +: 2] = 2'h3;
    rd_instr[`MAD_F_XWA +: 4] = 4'h3;
    do_reset();
    // unloaded words execute as unknowns until the second reset
    for (i = 0; i < 256; i++) begin
      put_word(8'(i), (i == 2) ? rd_instr : 160'h0);
    end
    // program at 0x10: sums from literal, square them twice, then freeze
    word = 160'h0;
    word[`MAD_F_RLD +: 12] = 12'h924;
    word[`MAD_F_LIT +: 16] = 16'h0100;
    put_word(8'h10, word);
    word = 160'h0;
    word[`MAD_F_MLS +: 12] = 12'hf55;
    word[`MAD_F_HALF] = 1'b1;
    put_word(8'h11, word);
    put_word(8'h12, word);
    for (i = 3; i < 8; i++) put_word(8'(16 + i), 160'h1);
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 5; i++) word[32*i +: 32] = $urandom;
      put_word(k ? 8'hff : 8'h00, word);
      get_word(k ? 8'hff : 8'h00, word);
      for (i = 5; i < 8; i++) begin
        reg_read({1'b0, k ? 8'hff : 8'h00, 3'(i)}, 32'h0);
      end
      put_word(k ? 8'hff : 8'h00, 160'h0);
    end
    do_reset();
    reg_write(12'h800, 32'hffffffff);
    reg_read(12'h800, 32'h0);
    reg_write(12'h803, 32'hfe);
    reg_read(12'h803, 32'hfe);
    reg_read(12'h803, 32'hff);
    reg_read(12'h803, 32'h0);
    dly_a <= 4'h6;
    reg_write(12'h803, 32'h2);
    idle(1);
    wait_for(1'b1);
    reg_read(12'h805, 32'h1);
    reg_read(12'h803, 32'h3);
    reg_read(12'h803, 32'h3);
    idle(1);
    wait_for(1'b0);
    reg_read(12'h805, 32'h0);
    reg_read(12'h800, 32'h0);
    dly_a <= 4'h0;
    reg_write(12'h803, 32'h10);
    idle(4);
    reg_read(12'h801, 32'h01000100);
    reg_read(12'h804, 32'h00000001);
    // with the enable low neither fetch nor a port write may move state
    reg_write(12'h803, 32'h40);
    idle(1);
    ce <= 1'b0;
    reg_write(12'h803, 32'h7);
    idle(2);
    ce <= 1'b1;
    reg_read(12'h803, 32'h41);
    idle(4);
    if (exp_q.size() != 0) fail_count++;
    summarize();
  end
endmodule // testbench
